// *** design/cct_pkg.sv ***
// Package for the completion credit tracker: credit pool sizes, boundaries, methods and carriers.
// Assumes one user clock shared by the request path and the completion path of the endpoint core.
package cct_pkg;

   // Receive buffer completion space of the endpoint core.
   localparam int unsigned HDR_TOTAL_DEF = 64;
   localparam int unsigned DATA_BYTES_TOTAL = 15872;
   localparam int unsigned CREDIT_BYTES = 16;
   localparam int unsigned DATA_TOTAL_DEF = DATA_BYTES_TOTAL / CREDIT_BYTES;
   // Defaults when configuration is not read.
   localparam int unsigned BOUNDARY_BYTES_DEF = 64;
   localparam int unsigned BOUNDARY_BYTES_ALT = 128;
   localparam int unsigned MAX_REQ_BYTES_DEF = 128;
   // Counter widths.
   localparam int unsigned CNT_W = 16;
   localparam int unsigned LEN_W = 13;
   localparam int unsigned TAG_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

   typedef enum logic [1:0]
   {
      CCT_FIXED_LIMIT,
      CCT_PER_PACKET,
      CCT_PER_BOUNDARY,
      CCT_PER_DATA
   } cct_method_e;

   typedef enum logic [1:0]
   {
      CCT_MEM_READ,
      CCT_IO_READ,
      CCT_IO_WRITE
   } cct_kind_e;

   // A non-posted request waiting for admission.
   typedef struct packed
   {
      logic [TAG_W-1:0] tag;
      cct_kind_e kind;
      logic [11:0] start_addr;
      logic [LEN_W-1:0] length_bytes;
   } cct_req_s;

   // One completion header as seen at its start.
   typedef struct packed
   {
      logic [TAG_W-1:0] tag;
      logic [6:0] lower_addr;
      logic [LEN_W-1:0] length_bytes;
      logic last;
   } cct_cpl_s;

endpackage : cct_pkg

// *** design/cct_tracker.sv ***
// Completion credit tracker: admits non-posted requests against endpoint completion space.
// Assumes completions are reported once per packet with tag, lower address, length and a last flag.
//
// What this block does
// - Fixed limit: headers per maximum read are ceiling of request size over the 64-byte boundary.
// - Data pool holds floor of data capacity over maximum request size completions.
// - Header pool holds floor of header total over headers per maximum read.
// - Outstanding request limit is the smaller of the two pool counts.
// - Outstanding count clears at reset and stays between zero and the limit.
// - Count moves by one on send and back once all completions arrived.
// - Credit methods keep pending header and data counters cleared at reset.
// - Header need is ceiling of boundary offset plus length over boundary.
// - Data need is ceiling of 16-byte offset plus length over 16; I/O write none.
// - Per packet: admit when each pending plus need is at most total; store needs.
// - Per packet: release the stored needs when the request's data is all back.
// - Per boundary: data need is header need times credits per boundary; strict admission.
// - Per boundary: release a header and a boundary of data per boundary block.
// - Boundary blocks are ceiling of lower address offset plus length over boundary.
// - Optionally one data credit per I/O read, none per I/O write, matched by tag.
// - Per data: release one header credit per boundary block, no data there.
// - Per data: release one data credit per 16-byte block of the completion.
// - Data totals may be scaled by two or four for finer granularity.
// - Boundary is 64 bytes unless set; setting bit one means 128 bytes.
// - Maximum read request size is 128 bytes unless configured.
`timescale 1ns/100ps

module cct_tracker #(
   parameter int unsigned HDR_TOTAL = cct_pkg::HDR_TOTAL_DEF,
   parameter int unsigned DATA_TOTAL = cct_pkg::DATA_TOTAL_DEF,
   parameter int unsigned MAX_REQ_BYTES = cct_pkg::MAX_REQ_BYTES_DEF,
   parameter int unsigned DATA_SCALE = 1,
   parameter bit IO_POLICY = 1'b0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire cct_pkg::cct_method_e method,
   input wire logic boundary_sel,
   input wire logic req_valid,
   input wire cct_pkg::cct_req_s req,
   output logic req_ready,
   output logic req_send,
   output cct_pkg::cct_req_s req_out,
   input wire logic cpl_valid,
   input wire cct_pkg::cct_cpl_s cpl,
   output logic [cct_pkg::CNT_W-1:0] outstanding_request_count,
   output logic [cct_pkg::CNT_W-1:0] pending_header_credits,
   output logic [cct_pkg::CNT_W-1:0] pending_data_credits
);

   localparam int unsigned TAGS = 1 << cct_pkg::TAG_W;
   localparam int unsigned W = cct_pkg::CNT_W;

   initial
   begin
      if (!(DATA_SCALE == 1 || DATA_SCALE == 2 || DATA_SCALE == 4))
      begin
         $error("DATA_SCALE must be 1, 2 or 4");
      end
      if (MAX_REQ_BYTES < 128 || MAX_REQ_BYTES > 4096)
      begin
         $error("MAX_REQ_BYTES out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers.

   // Ceiling of (offset + length) / unit, unit a power of two in bytes.
   function automatic logic [W-1:0] blocks(input logic [11:0] addr, input logic [cct_pkg::LEN_W-1:0] len,
                                           input int unsigned unit);
      logic [W-1:0] off;
      logic [W-1:0] sum;
      off = W'(addr % unit);
      sum = off + W'(len) + W'(unit - 1);
      return W'(sum / unit);
   endfunction : blocks

   ////////////////////////////////////////////////////////////////////////////
   // Static limits of the fixed-limit method.

   localparam int unsigned BND_DEF = cct_pkg::BOUNDARY_BYTES_DEF;
   localparam int unsigned HDR_PER_MAX = (MAX_REQ_BYTES + BND_DEF - 1) / BND_DEF;
   localparam int unsigned DATA_PKTS = (DATA_TOTAL * cct_pkg::CREDIT_BYTES) / MAX_REQ_BYTES;
   localparam int unsigned HDR_PKTS = HDR_TOTAL / HDR_PER_MAX;
   localparam int unsigned LIMIT = (HDR_PKTS < DATA_PKTS) ? HDR_PKTS : DATA_PKTS;
   localparam logic [W-1:0] LIMIT_W = W'(LIMIT);
   localparam logic [W-1:0] HDR_TOTAL_W = W'(HDR_TOTAL);
   localparam logic [W-1:0] DATA_TOTAL_W = W'(DATA_TOTAL * DATA_SCALE);

   ////////////////////////////////////////////////////////////////////////////
   // Request needs.

   wire [W-1:0] boundary_bytes = boundary_sel ? W'(cct_pkg::BOUNDARY_BYTES_ALT) : W'(BND_DEF);
   wire [W-1:0] data_per_boundary = W'((boundary_bytes / cct_pkg::CREDIT_BYTES) * DATA_SCALE);
   wire [W-1:0] hdr_need_64 = blocks(req.start_addr, req.length_bytes, 64);
   wire [W-1:0] hdr_need_128 = blocks(req.start_addr, req.length_bytes, 128);
   wire [W-1:0] request_header_need = boundary_sel ? hdr_need_128 : hdr_need_64;
   wire [W-1:0] data_need_raw = W'(blocks(req.start_addr, req.length_bytes, 16) * DATA_SCALE);
   wire io_write = (req.kind == cct_pkg::CCT_IO_WRITE);
   wire io_read = (req.kind == cct_pkg::CCT_IO_READ);
   wire [W-1:0] data_need_pkt = io_write ? '0 : data_need_raw;
   wire [W-1:0] data_need_bnd = io_write && IO_POLICY ? '0
                              : io_read && IO_POLICY ? W'(DATA_SCALE)
                              : W'(request_header_need * data_per_boundary);
   wire [W-1:0] request_data_need = (method == cct_pkg::CCT_PER_BOUNDARY) ? data_need_bnd : data_need_pkt;

   ////////////////////////////////////////////////////////////////////////////
   // Admission checks.

   wire [W:0] hdr_sum = {1'b0, pending_header_credits} + {1'b0, request_header_need};
   wire [W:0] data_sum = {1'b0, pending_data_credits} + {1'b0, request_data_need};
   wire fit_le = (hdr_sum <= {1'b0, HDR_TOTAL_W}) && (data_sum <= {1'b0, DATA_TOTAL_W});
   wire fit_lt = (hdr_sum < {1'b0, HDR_TOTAL_W}) && (data_sum < {1'b0, DATA_TOTAL_W});
   wire fit_fix = (outstanding_request_count < LIMIT_W);
   wire admit = (method == cct_pkg::CCT_FIXED_LIMIT) ? fit_fix
              : (method == cct_pkg::CCT_PER_PACKET) ? fit_le : fit_lt;
   wire busy_send = req_send;
   // The request is consumed only when admitted; otherwise it stays on req.
   wire take = req_valid && admit && !busy_send;

   ////////////////////////////////////////////////////////////////////////////
   // Completion release.

   wire [W-1:0] cpl_bnd_64 = blocks({5'h00, cpl.lower_addr}, cpl.length_bytes, 64);
   wire [W-1:0] cpl_bnd_128 = blocks({5'h00, cpl.lower_addr}, cpl.length_bytes, 128);
   wire [W-1:0] boundary_crossings = boundary_sel ? cpl_bnd_128 : cpl_bnd_64;
   wire [W-1:0] data_block_crossings = W'(blocks({5'h00, cpl.lower_addr}, cpl.length_bytes, 16) * DATA_SCALE);

   // Per-tag memory of needs and request kind.
   logic [W-1:0] tag_hdr_r [TAGS];
   logic [W-1:0] tag_data_r [TAGS];
   logic tag_io_r [TAGS];

   wire [W-1:0] st_hdr = tag_hdr_r[cpl.tag];
   wire [W-1:0] st_data = tag_data_r[cpl.tag];
   wire cpl_last = cpl_valid && cpl.last;
   // Under the I/O policy the data release of an I/O tag follows its stored reservation.
   wire [W-1:0] bnd_data_rel = (IO_POLICY && tag_io_r[cpl.tag]) ? st_data
                             : W'(boundary_crossings * data_per_boundary);

   // An I/O completion under the I/O policy returns no data credit when its tag reserved none.
   wire io_tag_zero = IO_POLICY && tag_io_r[cpl.tag] && (st_data == '0);

   logic [W-1:0] hdr_rel;
   logic [W-1:0] data_rel;
   always_comb
   begin
      hdr_rel = '0;
      data_rel = '0;
      if (cpl_valid)
      begin
         unique case (method)
            cct_pkg::CCT_FIXED_LIMIT:
            begin
               hdr_rel = '0;
               data_rel = '0;
            end
            cct_pkg::CCT_PER_PACKET:
            begin
               hdr_rel = cpl.last ? st_hdr : '0;
               data_rel = cpl.last ? st_data : '0;
            end
            cct_pkg::CCT_PER_BOUNDARY:
            begin
               hdr_rel = boundary_crossings;
               data_rel = bnd_data_rel;
            end
            cct_pkg::CCT_PER_DATA:
            begin
               hdr_rel = boundary_crossings;
               data_rel = io_tag_zero ? '0 : data_block_crossings;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter next values; releases saturate at zero to absorb oversized completions.

   wire [W-1:0] hdr_add = take ? request_header_need : '0;
   wire [W-1:0] data_add = take ? request_data_need : '0;
   wire [W-1:0] hdr_base = (pending_header_credits > hdr_rel) ? pending_header_credits - hdr_rel : '0;
   wire [W-1:0] data_base = (pending_data_credits > data_rel) ? pending_data_credits - data_rel : '0;
   wire use_credits = (method != cct_pkg::CCT_FIXED_LIMIT);
   wire [W-1:0] pending_header_credits_nxt = use_credits ? hdr_base + hdr_add : '0;
   wire [W-1:0] pending_data_credits_nxt = use_credits ? data_base + data_add : '0;
   // The count rises on send and falls on the last completion: zero is nothing outstanding.
   wire fix = (method == cct_pkg::CCT_FIXED_LIMIT);
   wire cnt_inc = fix && take;
   wire cnt_dec = fix && cpl_last && (outstanding_request_count != '0);
   wire [W-1:0] outstanding_request_count_nxt = outstanding_request_count
                                              + W'(cnt_inc) - W'(cnt_dec);

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Counters clear to zero at reset.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         outstanding_request_count <= cct_pkg::CNT_RESET;
         pending_header_credits <= cct_pkg::CNT_RESET;
         pending_data_credits <= cct_pkg::CNT_RESET;
      end
      else
      begin
         outstanding_request_count <= outstanding_request_count_nxt;
         pending_header_credits <= pending_header_credits_nxt;
         pending_data_credits <= pending_data_credits_nxt;
      end
   end

   // Needs are kept per tag for release and for I/O matching.
   always_ff @(posedge clk)
   begin
      if (take)
      begin
         tag_hdr_r[req.tag] <= request_header_need;
         tag_data_r[req.tag] <= request_data_need;
         tag_io_r[req.tag] <= io_read || io_write;
      end
   end

   // Send strobe and forwarded request; ready means the offered request was just taken.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         req_send <= 1'b0;
         req_ready <= 1'b0;
         req_out <= '0;
      end
      else
      begin
         req_send <= take;
         req_ready <= take;
         if (take)
         begin
            req_out <= req;
         end
      end
   end

endmodule : cct_tracker

// *** verif/cct_tracker_properties.sv ***
// Checker for the completion credit tracker: admission timing and counter bounds.
// Assumes it is bound to cct_tracker and sees only that module's ports.
`timescale 1ns/100ps
module cct_tracker_properties #(
   parameter int unsigned HDR_TOTAL = cct_pkg::HDR_TOTAL_DEF,
   parameter int unsigned DATA_TOTAL = cct_pkg::DATA_TOTAL_DEF,
   parameter int unsigned MAX_REQ_BYTES = cct_pkg::MAX_REQ_BYTES_DEF,
   parameter int unsigned DATA_SCALE = 1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire cct_pkg::cct_method_e method,
   input wire logic req_valid,
   input wire cct_pkg::cct_req_s req,
   input wire logic req_ready,
   input wire logic req_send,
   input wire cct_pkg::cct_req_s req_out,
   input wire logic cpl_valid,
   input wire logic [cct_pkg::CNT_W-1:0] outstanding_request_count,
   input wire logic [cct_pkg::CNT_W-1:0] pending_header_credits,
   input wire logic [cct_pkg::CNT_W-1:0] pending_data_credits
);
   ////////////////////////////////////////////////////////////////////////////
   // The fixed limit always assumes a 64-byte boundary, as the tracker does.
   localparam int unsigned HPR = (MAX_REQ_BYTES + 63) / 64;
   localparam int unsigned LIM_H = HDR_TOTAL / HPR;
   localparam int unsigned LIM_D = DATA_TOTAL * 16 / MAX_REQ_BYTES;
   localparam int unsigned LIMIT = (LIM_H < LIM_D) ? LIM_H : LIM_D;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_reset_clear;
      disable iff (1'b0) rst |=> (outstanding_request_count == 0 && pending_header_credits == 0
         && pending_data_credits == 0 && !req_send);
   endproperty
   property p_pair;
      req_send == req_ready;
   endproperty
   property p_spacing;
      req_send |=> !req_send;
   endproperty
   property p_send_cause;
      req_send |-> $past(req_valid) && req_out == $past(req);
   endproperty
   property p_fixed_bound;
      method == cct_pkg::CCT_FIXED_LIMIT |-> outstanding_request_count <= LIMIT;
   endproperty
   property p_fixed_step;
      outstanding_request_count <= $past(outstanding_request_count) + 1
         && outstanding_request_count + 1 >= $past(outstanding_request_count);
   endproperty
   property p_inc_on_send;
      outstanding_request_count > $past(outstanding_request_count) |-> req_send;
   endproperty
   property p_packet_bound;
      method == cct_pkg::CCT_PER_PACKET |-> pending_header_credits <= HDR_TOTAL
         && pending_data_credits <= DATA_TOTAL * DATA_SCALE;
   endproperty
   property p_strict_bound;
      method inside {cct_pkg::CCT_PER_BOUNDARY, cct_pkg::CCT_PER_DATA} |->
         pending_header_credits < HDR_TOTAL && pending_data_credits < DATA_TOTAL * DATA_SCALE;
   endproperty
   property p_data_release;
      cpl_valid && method == cct_pkg::CCT_PER_DATA && pending_data_credits != 0 |=>
         pending_data_credits < $past(pending_data_credits) || req_send;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("counters not clear after reset");
   a_pair: assert property (p_pair) else $error("send and ready differ");
   a_spacing: assert property (p_spacing) else $error("two sends back to back");
   a_send_cause: assert property (p_send_cause) else $error("sent request differs from offer");
   a_fixed_bound: assert property (p_fixed_bound) else $error("outstanding count above limit");
   a_fixed_step: assert property (p_fixed_step) else $error("outstanding count jumped");
   a_inc_on_send: assert property (p_inc_on_send) else $error("count rose without send");
   a_packet_bound: assert property (p_packet_bound) else $error("packet credits overrun");
   a_strict_bound: assert property (p_strict_bound) else $error("strict credit bound broken");
   a_data_release: assert property (p_data_release) else $error("no data credit released");
   // Main scenarios: limit reached, request held, boundary release.
   c_limit: cover property (outstanding_request_count == LIMIT);
   c_held: cover property (req_valid && !req_send [*4]);
   c_rcb: cover property (cpl_valid && method == cct_pkg::CCT_PER_BOUNDARY);
endmodule : cct_tracker_properties

bind cct_tracker cct_tracker_properties #(.HDR_TOTAL(HDR_TOTAL), .DATA_TOTAL(DATA_TOTAL),
   .MAX_REQ_BYTES(MAX_REQ_BYTES), .DATA_SCALE(DATA_SCALE)) cct_tracker_properties_i (.clk, .rst,
   .method, .req_valid, .req, .req_ready, .req_send, .req_out, .cpl_valid,
   .outstanding_request_count, .pending_header_credits, .pending_data_credits);

// *** verif/cct_endpoint_model.sv ***
// Endpoint core model: queues sent requests and returns one completion for each.
// Assumes the bench raises drain to let completions flow, one every other cycle.
`timescale 1ns/100ps
module cct_endpoint_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic drain,
   input wire logic req_send,
   input wire cct_pkg::cct_req_s req_out,
   output logic cpl_valid,
   output cct_pkg::cct_cpl_s cpl
);
   cct_pkg::cct_req_s pend[$];
   cct_pkg::cct_req_s head;
   ////////////////////////////////////////////////////////////////////////////
   // Completions are whole, so a held header field never looks valid: idle bits toggle.
   always @(posedge clk)
   begin
      if (rst)
      begin
         pend.delete();
         cpl_valid <= 1'b0;
         cpl <= '0;
      end
      else
      begin
         if (req_send)
            pend.push_back(req_out);
         if (pend.size() > cct_pkg::HDR_TOTAL_DEF)
            $error("endpoint header space overrun");
         cpl_valid <= 1'b0;
         cpl <= ~cpl;
         if (drain && !cpl_valid && pend.size() > 0)
         begin
            head = pend.pop_front();
            cpl_valid <= 1'b1;
            cpl <= '{tag: head.tag, lower_addr: head.start_addr[6:0], length_bytes: head.length_bytes, last: 1'b1};
         end
      end
   end
endmodule : cct_endpoint_model

// *** verif/tb_completion_credit_tracker.sv ***
// Testbench for the completion credit tracker, one task per scenario.
// Assumes the endpoint model answers every request with a single completion.
`timescale 1ns/100ps
module tb_completion_credit_tracker;
   logic clk = 0, rst = 1, req_valid = 0, drain = 0, boundary_sel = 0;
   logic req_send, req_ready, cpl_valid;
   cct_pkg::cct_method_e method = cct_pkg::CCT_PER_PACKET;
   cct_pkg::cct_req_s req = '0, req_out;
   cct_pkg::cct_cpl_s cpl;
   logic [15:0] oc, hc, dc;
   int fails = 0, n_tests = 0, tg = 0;
   bit ok;
   always #5 clk = ~clk;
   cct_tracker cct_tracker_i (.clk, .rst, .method, .boundary_sel, .req_valid, .req, .req_ready, .req_send,
      .req_out, .cpl_valid, .cpl, .outstanding_request_count(oc), .pending_header_credits(hc),
      .pending_data_credits(dc));
   cct_endpoint_model cct_endpoint_model_i (.clk, .rst, .drain, .req_send, .req_out, .cpl_valid, .cpl);
   ////////////////////////////////////////////////////////////////////////////
   // Shared compare, verdict and handshake tasks.
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // A refused offer stays up, so the caller can keep holding it.
   task send(input logic [11:0] a, input logic [12:0] len, input cct_pkg::cct_kind_e k, input int n, input bit e);
      ok = 0;
      req <= '{tag: tg[7:0], kind: k, start_addr: a, length_bytes: len};
      req_valid <= 1'b1;
      repeat (n)
      begin
         @(posedge clk);
         if (req_send === 1'b1)
         begin
            ok = 1;
            break;
         end
      end
      if (ok)
      begin
         check("ready", req_ready, 1);
         check("req_out tag", req_out.tag, tg[7:0]);
         req_valid <= 1'b0;
         tg++;
         @(posedge clk);
      end
      check("sent", ok, e);
      if (e && !ok)
         close_out();
   endtask : send
   task drain_all;
      drain <= 1'b1;
      ok = 0;
      repeat (300)
      begin
         @(posedge clk);
         if (oc === 0 && hc === 0 && dc === 0)
         begin
            ok = 1;
            break;
         end
      end
      drain <= 1'b0;
      check("drained", ok, 1);
      if (!ok)
         close_out();
      @(posedge clk);
   endtask : drain_all
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task t_packet;
      check("reset oc", oc, 0);
      check("reset hc", hc, 0);
      check("reset dc", dc, 0);
      send(12'h07C, 8, cct_pkg::CCT_MEM_READ, 20, 1);
      check("pkt hc", hc, 2);
      check("pkt dc", dc, 2);
      send(12'h000, 4, cct_pkg::CCT_IO_WRITE, 20, 1);
      check("iow hc", hc, 3);
      check("iow dc", dc, 2);
      drain_all();
      $display("packet test done");
   endtask : t_packet
   task t_fixed;
      method <= cct_pkg::CCT_FIXED_LIMIT;
      @(posedge clk);
      repeat (32)
         send(12'h000, 128, cct_pkg::CCT_MEM_READ, 20, 1);
      check("at limit", oc, 32);
      send(12'h000, 128, cct_pkg::CCT_MEM_READ, 8, 0);
      drain <= 1'b1;
      @(posedge clk);
      drain <= 1'b0;
      send(12'h000, 128, cct_pkg::CCT_MEM_READ, 20, 1);
      check("refilled", oc, 32);
      drain_all();
      $display("fixed test done");
   endtask : t_fixed
   task t_boundary;
      method <= cct_pkg::CCT_PER_BOUNDARY;
      boundary_sel <= 1'b1;
      @(posedge clk);
      send(12'h000, 128, cct_pkg::CCT_MEM_READ, 20, 1);
      check("rcb dc", dc, 8);
      send(12'h040, 128, cct_pkg::CCT_MEM_READ, 20, 1);
      check("rcb hc", hc, 3);
      check("rcb dc2", dc, 24);
      drain_all();
      $display("boundary test done");
   endtask : t_boundary
   task t_data;
      method <= cct_pkg::CCT_PER_DATA;
      boundary_sel <= 1'b0;
      @(posedge clk);
      send(12'h030, 64, cct_pkg::CCT_MEM_READ, 20, 1);
      check("data hc", hc, 2);
      check("data dc", dc, 4);
      drain_all();
      $display("data test done");
   endtask : t_data
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for ten cycles, then every scenario in turn.
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_packet();
      t_fixed();
      t_boundary();
      t_data();
      close_out();
   end
endmodule : tb_completion_credit_tracker
